// *** design/stm_consts.svh ***
`ifndef STM_CONSTS_SVH
`define STM_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte addresses on the AXI4-Lite bus
// ----------------------------------------------------------------------
`define STM_ADDR_CTRL0   8'h00
`define STM_ADDR_CTRL1   8'h04
`define STM_ADDR_CNT_LO  8'h08
`define STM_ADDR_CNT_HI  8'h0C
`define STM_ADDR_CMPA_LO 8'h10
`define STM_ADDR_CMPA_HI 8'h14
`define STM_ADDR_STATUS  8'h18
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STM_C0_PAUSE     7
`define STM_C0_CLK       6:4
`define STM_C0_RUN       3
`define STM_C0_PERIOD    2:0
`define STM_C1_MODE      7:6
`define STM_C1_IO        5:4
`define STM_C1_OC        3
`define STM_C1_POL       2
`define STM_C1_CCLR      0
`define STM_ST_FLAG_A    0
`define STM_ST_FLAG_P    1
`define STM_ST_PIN1_INV  4
// ----------------------------------------------------------------------
// Reset values, codes and counts
// ----------------------------------------------------------------------
`define STM_CTRL_RESET   8'h00
`define STM_RESP_OKAY    2'h0
`define STM_RESP_SLVERR  2'h2
`define STM_CLK_SYS4     3'h0
`define STM_CLK_SYS      3'h1
`define STM_CLK_HI16     3'h2
`define STM_CLK_HI64     3'h3
`define STM_CLK_TB0      3'h4
`define STM_CLK_TB1      3'h5
`define STM_CLK_EXT_RISE 3'h6
`define STM_CLK_EXT_FALL 3'h7
`define STM_PRE_DIV4     2'h3
`define STM_PRE_DIV16    4'hF
`define STM_PRE_DIV64    6'h3F
`define STM_IO_00        2'h0
`define STM_IO_01        2'h1
`define STM_IO_10        2'h2
`define STM_IO_11        2'h3
`endif

// *** design/stm_pkg.sv ***
package stm_pkg;
  // Operating mode codes as held in the mode field
  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'h0,
    STM_MODE_CAPTURE = 2'h1,
    STM_MODE_PWM     = 2'h2,
    STM_MODE_TIMER   = 2'h3
  } stm_mode_type;

  // Whole state of the timer core, registered as one word
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] buffer;
    logic [9:0] cmpa;
    logic [9:0] count;
    logic       flag_a;
    logic       flag_p;
    logic       pin1_inv;
    logic       level;
    logic       pulse_done;
    logic [5:0] pres;
    logic [1:0] ext_sync;
    logic [1:0] tb_sync;
    logic [1:0] cap_sync;
    logic       ext_q;
    logic       tb_q;
    logic       cap_q;
    logic [7:0] aw_addr;
    logic       aw_full;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       w_full;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic       pin0;
    logic       pin1;
  } stm_state_type;
endpackage : stm_pkg

// *** design/stm_core.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "stm_consts.svh"

module stm_core #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Asynchronous pins
  input  wire logic              external_clock_pin,
  input  wire logic              timebase_clock,
  input  wire logic              capture_pin,
  // Status and timer outputs
  output logic                   compare_a_flag,
  output logic                   compare_p_flag,
  output stm_pkg::stm_mode_type  mode_out,
  output logic                   timer_out0,
  output logic                   timer_out1
);
  import stm_pkg::*;

  // ----------------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------------
  stm_state_type s;
  stm_state_type next_s;
  logic          wr_fire;
  logic          rd_fire;
  logic          run_rise;
  logic          tick;
  logic          count_en;
  logic          match_a;
  logic          match_p;
  logic          cap_edge;
  logic [10:0]   inc;
  stm_mode_type  mode;

  // True when the address selects the given register word
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] reg_addr);
    hit = (a[7:2] == reg_addr[7:2]);
  endfunction : hit

  // Edge detect on a synchronised pin
  function automatic logic pin_edge(input logic now, input logic prev, input logic fall);
    pin_edge = fall ? (prev && !now) : (now && !prev);
  endfunction : pin_edge

  // Mapped address check for the bus answer
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, `STM_ADDR_CTRL0) || hit(a, `STM_ADDR_CTRL1) ||
             hit(a, `STM_ADDR_CNT_LO) || hit(a, `STM_ADDR_CNT_HI) ||
             hit(a, `STM_ADDR_CMPA_LO) || hit(a, `STM_ADDR_CMPA_HI) ||
             hit(a, `STM_ADDR_STATUS);
  endfunction : mapped

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Pin synchronisers; only the second stage feeds logic
    next_s.ext_sync = {s.ext_sync[0], external_clock_pin};
    next_s.tb_sync  = {s.tb_sync[0], timebase_clock};
    next_s.cap_sync = {s.cap_sync[0], capture_pin};
    next_s.ext_q    = s.ext_sync[1];
    next_s.tb_q     = s.tb_sync[1];
    next_s.cap_q    = s.cap_sync[1];
    next_s.pres     = s.pres + 6'h01;

    // Write address and data may arrive in either order
    if (awvalid && s.awready) begin
      next_s.aw_addr = awaddr[7:0];
      next_s.aw_full = 1'h1;
    end
    if (wvalid && s.wready) begin
      next_s.w_data  = wdata[7:0];
      next_s.w_lane0 = wstrb[0];
      next_s.w_full  = 1'h1;
    end
    wr_fire = s.aw_full && s.w_full && !s.bvalid;
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'h0;
    end
    if (wr_fire) begin
      next_s.aw_full = 1'h0;
      next_s.w_full  = 1'h0;
      next_s.bvalid  = 1'h1;
      next_s.bresp   = mapped(s.aw_addr) ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
      // Only byte lane 0 carries register data; other lanes are ignored
      if (s.w_lane0) begin
        if (hit(s.aw_addr, `STM_ADDR_CTRL0)) begin
          next_s.ctrl0 = s.w_data;
        end else if (hit(s.aw_addr, `STM_ADDR_CTRL1)) begin
          next_s.ctrl1 = s.w_data;
        end else if (hit(s.aw_addr, `STM_ADDR_CMPA_LO)) begin
          next_s.buffer = s.w_data;
        end else if (hit(s.aw_addr, `STM_ADDR_CMPA_HI)) begin
          next_s.cmpa = {s.w_data[1:0], s.buffer};
        end else if (hit(s.aw_addr, `STM_ADDR_STATUS)) begin
          if (s.w_data[`STM_ST_FLAG_A]) next_s.flag_a = 1'h0;
          if (s.w_data[`STM_ST_FLAG_P]) next_s.flag_p = 1'h0;
          next_s.pin1_inv = s.w_data[`STM_ST_PIN1_INV];
        end
      end
    end

    // Read: answer next cycle; high byte reads latch the low byte
    rd_fire = arvalid && s.arready;
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'h0;
    end
    if (rd_fire) begin
      next_s.rvalid = 1'h1;
      next_s.rresp  = mapped(araddr) ? `STM_RESP_OKAY : `STM_RESP_SLVERR;
      next_s.rdata  = 8'h00;
      if (hit(araddr, `STM_ADDR_CTRL0)) begin
        next_s.rdata = s.ctrl0;
      end else if (hit(araddr, `STM_ADDR_CTRL1)) begin
        next_s.rdata = s.ctrl1;
      end else if (hit(araddr, `STM_ADDR_CNT_LO) || hit(araddr, `STM_ADDR_CMPA_LO)) begin
        next_s.rdata = s.buffer;
      end else if (hit(araddr, `STM_ADDR_CNT_HI)) begin
        next_s.rdata  = {6'h00, s.count[9:8]};
        next_s.buffer = s.count[7:0];
      end else if (hit(araddr, `STM_ADDR_CMPA_HI)) begin
        next_s.rdata  = {6'h00, s.cmpa[9:8]};
        next_s.buffer = s.cmpa[7:0];
      end else if (hit(araddr, `STM_ADDR_STATUS)) begin
        next_s.rdata = {3'h0, s.pin1_inv, 2'h0, s.flag_p, s.flag_a};
      end
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready  = !next_s.w_full && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // Counter clock source; the high clock is taken equal to the system clock
    case (s.ctrl0[`STM_C0_CLK])
      `STM_CLK_SYS4:     tick = (s.pres[1:0] == `STM_PRE_DIV4);
      `STM_CLK_SYS:      tick = 1'h1;
      `STM_CLK_HI16:     tick = (s.pres[3:0] == `STM_PRE_DIV16);
      `STM_CLK_HI64:     tick = (s.pres == `STM_PRE_DIV64);
      `STM_CLK_TB0,
      `STM_CLK_TB1:      tick = pin_edge(s.tb_sync[1], s.tb_q, 1'h0);
      `STM_CLK_EXT_RISE: tick = pin_edge(s.ext_sync[1], s.ext_q, 1'h0);
      default:           tick = pin_edge(s.ext_sync[1], s.ext_q, 1'h1);
    endcase

    mode     = stm_mode_type'(s.ctrl1[`STM_C1_MODE]);
    run_rise = !s.ctrl0[`STM_C0_RUN] && next_s.ctrl0[`STM_C0_RUN];
    count_en = s.ctrl0[`STM_C0_RUN] && !s.ctrl0[`STM_C0_PAUSE] && tick;
    inc      = {1'h0, s.count} + 11'h001;
    match_a  = count_en && (inc[9:0] == s.cmpa);
    // Code zero waits for the wrap, otherwise bits 9..7 reach the period
    if (s.ctrl0[`STM_C0_PERIOD] == 3'h0) begin
      match_p = count_en && inc[10];
    end else begin
      match_p = count_en && (inc[9:7] == s.ctrl0[`STM_C0_PERIOD]) && (inc[6:0] == 7'h00);
    end

    // Counter: run edge clears, selected match clears, else step
    if (run_rise) begin
      next_s.count      = 10'h000;
      next_s.pulse_done = 1'h0;
    end else if (count_en) begin
      if (s.ctrl1[`STM_C1_CCLR] && (mode == STM_MODE_COMPARE || mode == STM_MODE_TIMER)) begin
        next_s.count = match_a ? 10'h000 : inc[9:0];
      end else begin
        next_s.count = match_p ? 10'h000 : inc[9:0];
      end
    end

    // Flags: the set is applied after software clears so it wins
    cap_edge = 1'h0;
    if (mode == STM_MODE_CAPTURE) begin
      case (s.ctrl1[`STM_C1_IO])
        `STM_IO_00: cap_edge = pin_edge(s.cap_sync[1], s.cap_q, 1'h0);
        `STM_IO_01: cap_edge = pin_edge(s.cap_sync[1], s.cap_q, 1'h1);
        `STM_IO_10: cap_edge = (s.cap_sync[1] != s.cap_q);
        default:    cap_edge = 1'h0;
      endcase
      if (cap_edge) begin
        next_s.cmpa   = s.count;
        next_s.flag_a = 1'h1;
      end
    end else if (match_a) begin
      next_s.flag_a = 1'h1;
    end
    if (match_p && !(s.ctrl1[`STM_C1_CCLR] && (mode == STM_MODE_COMPARE ||
                                                mode == STM_MODE_TIMER))) begin
      next_s.flag_p = 1'h1;
    end

    // Output level before polarity
    if (mode == STM_MODE_COMPARE) begin
      if (run_rise) begin
        next_s.level = s.ctrl1[`STM_C1_OC];
      end else if (match_a) begin
        case (s.ctrl1[`STM_C1_IO])
          `STM_IO_01: next_s.level = 1'h0;
          `STM_IO_10: next_s.level = 1'h1;
          `STM_IO_11: next_s.level = !s.level;
          default:    next_s.level = s.level;
        endcase
      end
    end else if (mode == STM_MODE_PWM) begin
      if (match_a) begin
        next_s.pulse_done = 1'h1;
      end
      // Active level is the initial level bit
      case (s.ctrl1[`STM_C1_IO])
        `STM_IO_00: next_s.level = !s.ctrl1[`STM_C1_OC];
        `STM_IO_01: next_s.level = s.ctrl1[`STM_C1_OC];
        `STM_IO_10: next_s.level = (next_s.count < s.cmpa) ? s.ctrl1[`STM_C1_OC]
                                                          : !s.ctrl1[`STM_C1_OC];
        default:    next_s.level = (next_s.ctrl0[`STM_C0_RUN] && !next_s.pulse_done)
                                   ? s.ctrl1[`STM_C1_OC] : !s.ctrl1[`STM_C1_OC];
      endcase
    end

    // Pins: timer mode leaves them idle low, so polarity is moot there
    if (mode == STM_MODE_TIMER) begin
      next_s.pin0 = 1'h0;
      next_s.pin1 = 1'h0;
    end else begin
      next_s.pin0 = next_s.level ^ s.ctrl1[`STM_C1_POL];
      next_s.pin1 = next_s.level ^ s.ctrl1[`STM_C1_POL] ^ next_s.pin1_inv;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Control registers clear to an idle timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s         <= '0;
      s.ctrl0   <= `STM_CTRL_RESET;
      s.ctrl1   <= `STM_CTRL_RESET;
      s.awready <= 1'h1;
      s.wready  <= 1'h1;
      s.arready <= 1'h1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign awready        = s.awready;
  assign wready         = s.wready;
  assign bvalid         = s.bvalid;
  assign bresp          = s.bresp;
  assign arready        = s.arready;
  assign rvalid         = s.rvalid;
  assign rresp          = s.rresp;
  assign rdata          = {24'h00_0000, s.rdata};
  assign compare_a_flag = s.flag_a;
  assign compare_p_flag = s.flag_p;
  assign mode_out       = stm_mode_type'(s.ctrl1[`STM_C1_MODE]);
  assign timer_out0     = s.pin0;
  assign timer_out1     = s.pin1;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_low_write_buf: assert property (
    (wr_fire && s.w_lane0 && hit(s.aw_addr, `STM_ADDR_CMPA_LO) && mode != STM_MODE_CAPTURE)
    |=> (s.buffer == $past(s.w_data)) && (s.cmpa[7:0] == $past(s.cmpa[7:0])))
    else $error("low byte write reached compare value");
  chk_high_write_copy: assert property (
    (wr_fire && s.w_lane0 && hit(s.aw_addr, `STM_ADDR_CMPA_HI) && mode != STM_MODE_CAPTURE)
    |=> s.cmpa == {$past(s.w_data[1:0]), $past(s.buffer)})
    else $error("high byte write did not copy buffer");
  chk_high_read_latch: assert property (
    (rd_fire && hit(araddr, `STM_ADDR_CNT_HI))
    |=> (s.buffer == $past(s.count[7:0])) && (s.rdata[1:0] == $past(s.count[9:8])))
    else $error("counter high read did not latch low byte");
  chk_low_read_buf: assert property (
    (rd_fire && hit(araddr, `STM_ADDR_CMPA_LO)) |=> s.rvalid && (s.rdata == $past(s.buffer)))
    else $error("low byte read did not return buffer");
  chk_pause_hold: assert property (
    (s.ctrl0[`STM_C0_PAUSE] && !run_rise) |=> $stable(s.count))
    else $error("count moved while paused");
  chk_run_clear: assert property (
    run_rise |=> (s.count == 10'h000) && s.ctrl0[`STM_C0_RUN])
    else $error("run edge did not clear counter");
  chk_count_step: assert property (
    (!run_rise && !count_en) |=> $stable(s.count))
    else $error("count changed without a tick");
  chk_clear_a_only: assert property (
    (s.ctrl1[`STM_C1_CCLR] && mode == STM_MODE_COMPARE && !s.flag_p && !wr_fire)
    |=> !s.flag_p)
    else $error("P flag set while clearing on A");
  chk_initial_level: assert property (
    (run_rise && mode == STM_MODE_COMPARE)
    |=> s.pin0 == ($past(s.ctrl1[`STM_C1_OC]) ^ $past(s.ctrl1[`STM_C1_POL])))
    else $error("pin not set to initial level");

  cov_match_a: cover property (match_a && mode == STM_MODE_COMPARE);
  cov_overflow: cover property (match_p && s.ctrl0[`STM_C0_PERIOD] == 3'h0);
  cov_capture: cover property (cap_edge);
  cov_both_rw: cover property (wr_fire && rd_fire);
endmodule : stm_core
`default_nettype wire

// *** bench/stm_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host software on the register bus, one word access at a time
module stm_host_model (
  // Clock
  input  wire logic        clk,
  // Write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // Read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h00_0000, d};
    wstrb   <= 4'h1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    r = rresp;
  endtask : rd

  // Pairs: low byte first on writes, high byte first on reads
  task automatic wr16(input logic [7:0] lo, input logic [9:0] v);
    logic [1:0] r;
    wr(lo, v[7:0], r);
    wr(lo + 8'h04, {6'h00, v[9:8]}, r);
  endtask : wr16

  task automatic rd16(input logic [7:0] lo, output logic [9:0] v);
    logic [7:0] hi;
    logic [7:0] lb;
    logic [1:0] r;
    rd(lo + 8'h04, hi, r);
    rd(lo, lb, r);
    v = {hi[1:0], lb};
  endtask : rd16
endmodule : stm_host_model
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "stm_consts.svh"
module testbench;
  import stm_pkg::*;
  // --------
  // Signals
  // --------
  logic [31:0]  wdata, rdata;
  logic [7:0]   awaddr, araddr, rd8;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, resp;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready;
  logic         compare_a_flag, compare_p_flag, timer_out0, timer_out1;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         external_clock_pin = 1'b0;
  logic         timebase_clock = 1'b0;
  logic         capture_pin = 1'b0;
  logic [9:0]   v10, w10;
  stm_mode_type mode_out;
  int           mismatches = 0;
  int           compares = 0;

  always #5 clk = ~clk;
  // Pin clocks of 6 and 8 cycles, slow enough for the synchronisers
  always begin
    repeat (3) @(posedge clk);
    external_clock_pin <= ~external_clock_pin;
  end
  always begin
    repeat (4) @(posedge clk);
    timebase_clock <= ~timebase_clock;
  end

  stm_core stm_core_inst (.clk(clk), .reset_n(reset_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .external_clock_pin(external_clock_pin), .timebase_clock(timebase_clock),
    .capture_pin(capture_pin), .compare_a_flag(compare_a_flag),
    .compare_p_flag(compare_p_flag), .mode_out(mode_out),
    .timer_out0(timer_out0), .timer_out1(timer_out1));

  stm_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // --------
  // Helpers
  // --------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, resp);
  endtask : w

  // Skip the first, irregular gap, then count cycles of one full gap
  task automatic meas(input int exp);
    int n;
    logic v;
    n = 0;
    @(posedge clk);
    v = timer_out0;
    while (timer_out0 === v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    v = timer_out0;
    n = 0;
    while (timer_out0 === v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("toggle_gap", exp, n);
  endtask : meas

  // --------
  // Scenarios
  // --------
  task automatic t_reset;
    host.rd(`STM_ADDR_CTRL0, rd8, resp);
    chk("ctrl0", `STM_CTRL_RESET, rd8);
    chk("rresp", `STM_RESP_OKAY, resp);
    w(`STM_ADDR_CTRL1, 8'h00);
    chk("wresp", `STM_RESP_OKAY, resp);
    w(8'h1C, 8'h00);
    chk("unmapped_wresp", `STM_RESP_SLVERR, resp);
    host.rd(`STM_ADDR_CTRL1, rd8, resp);
    chk("ctrl1", `STM_CTRL_RESET, rd8);
    chk("mode", STM_MODE_COMPARE, mode_out);
    host.rd(8'h1C, rd8, resp);
    chk("unmapped_resp", `STM_RESP_SLVERR, resp);
    host.wr16(`STM_ADDR_CMPA_LO, 10'h2A5);
    host.rd16(`STM_ADDR_CMPA_LO, v10);
    chk("cmpa", 10'h2A5, v10);
    w(`STM_ADDR_CMPA_LO, 8'h33);
    host.rd16(`STM_ADDR_CMPA_LO, v10);
    chk("cmpa_low_kept", 10'h2A5, v10);
    $display("test reset_and_pairs done");
  endtask : t_reset

  task automatic t_clock;
    int div [8] = '{4, 1, 16, 64, 8, 8, 6, 6};
    w(`STM_ADDR_CTRL1, 8'h31);
    host.wr16(`STM_ADDR_CMPA_LO, 10'h004);
    for (int c = 0; c < 8; c++) begin
      w(`STM_ADDR_CTRL0, 8'h00);
      w(`STM_ADDR_STATUS, 8'h03);
      w(`STM_ADDR_CTRL0, {1'b0, c[2:0], 4'h8});
      meas(4 * div[c]);
    end
    chk("flag_a", 1, compare_a_flag);
    chk("flag_p", 0, compare_p_flag);
    $display("test clock_select done");
  endtask : t_clock

  task automatic t_period;
    w(`STM_ADDR_CTRL1, 8'h38);
    host.wr16(`STM_ADDR_CMPA_LO, 10'h00A);
    for (int p = 0; p < 8; p++) begin
      w(`STM_ADDR_CTRL0, 8'h00);
      w(`STM_ADDR_CTRL0, {5'h03, p[2:0]});
      chk("initial_level", 1, timer_out0);
      meas(p == 0 ? 1024 : 128 * p);
    end
    chk("flag_p", 1, compare_p_flag);
    $display("test period done");
  endtask : t_period

  task automatic t_pause;
    w(`STM_ADDR_CTRL0, 8'h00);
    w(`STM_ADDR_CTRL1, 8'h31);
    host.wr16(`STM_ADDR_CMPA_LO, 10'h3E8);
    w(`STM_ADDR_CTRL0, 8'h18);
    repeat (40) @(posedge clk);
    w(`STM_ADDR_CTRL0, 8'h98);
    host.rd16(`STM_ADDR_CNT_LO, v10);
    repeat (20) @(posedge clk);
    host.rd16(`STM_ADDR_CNT_LO, w10);
    chk("paused", v10, w10);
    w(`STM_ADDR_CTRL0, 8'h18);
    repeat (20) @(posedge clk);
    host.rd16(`STM_ADDR_CNT_LO, w10);
    chk("resumed", 1, w10 > v10 && w10 < v10 + 10'd60);
    w(`STM_ADDR_CTRL0, 8'h10);
    host.rd16(`STM_ADDR_CNT_LO, v10);
    repeat (20) @(posedge clk);
    host.rd16(`STM_ADDR_CNT_LO, w10);
    chk("stopped", 1, v10 == w10 && v10 > 10'd40);
    w(`STM_ADDR_CTRL0, 8'h18);
    host.rd16(`STM_ADDR_CNT_LO, w10);
    chk("restart_zero", 1, w10 < 10'd20);
    $display("test pause_run done");
  endtask : t_pause

  task automatic t_output;
    w(`STM_ADDR_CTRL0, 8'h00);
    w(`STM_ADDR_CTRL1, 8'h3C);
    w(`STM_ADDR_CTRL0, 8'h18);
    chk("inverted_level", 0, timer_out0);
    w(`STM_ADDR_STATUS, 8'h10);
    chk("pin1", 1, timer_out1);
    for (int i = 0; i < 2; i++) begin
      w(`STM_ADDR_CTRL0, 8'h00);
      w(`STM_ADDR_CTRL1, {2'b10, i[1:0], 4'h8});
      w(`STM_ADDR_CTRL0, 8'h18);
      chk("pwm_force", i[0], timer_out0);
      chk("pwm_pin1", !i[0], timer_out1);
    end
    w(`STM_ADDR_CTRL0, 8'h00);
    w(`STM_ADDR_CTRL1, 8'hCC);
    w(`STM_ADDR_CTRL0, 8'h18);
    chk("mode", STM_MODE_TIMER, mode_out);
    chk("timer_pins", 0, {timer_out0, timer_out1});
    w(`STM_ADDR_STATUS, 8'h00);
    $display("test outputs done");
  endtask : t_output

  // Drive-low then drive-high match actions, each from the opposite start level
  task automatic t_match;
    host.wr16(`STM_ADDR_CMPA_LO, 10'h010);
    for (int i = 1; i < 3; i++) begin
      w(`STM_ADDR_CTRL0, 8'h00);
      w(`STM_ADDR_CTRL1, {2'b00, i[1:0], i[0], 3'h1});
      w(`STM_ADDR_CTRL0, 8'h18);
      chk("match_before", i[0], timer_out0);
      repeat (40) @(posedge clk);
      chk("match_after", i[1], timer_out0);
    end
    $display("test match_actions done");
  endtask : t_match

  // Duty of 16 in a 128 period, then one pulse of 16 ticks
  task automatic t_pwm;
    int n;
    w(`STM_ADDR_CTRL0, 8'h00);
    w(`STM_ADDR_CTRL1, 8'hA8);
    w(`STM_ADDR_CTRL0, 8'h19);
    n = 0;
    repeat (256) begin
      @(posedge clk);
      if (timer_out0 === 1'b1) n++;
    end
    chk("pwm_duty", 32, n);
    w(`STM_ADDR_CTRL0, 8'h00);
    w(`STM_ADDR_CTRL1, 8'hB8);
    w(`STM_ADDR_CTRL0, 8'h19);
    chk("pulse_on", 1, timer_out0);
    repeat (40) @(posedge clk);
    chk("pulse_off", 0, timer_out0);
    $display("test pwm_pulse done");
  endtask : t_pwm

  task automatic t_capture;
    for (int i = 0; i < 4; i++) begin
      w(`STM_ADDR_CTRL0, 8'h00);
      w(`STM_ADDR_CTRL1, {2'b01, i[1:0], 4'h0});
      w(`STM_ADDR_CTRL0, 8'h18);
      w(`STM_ADDR_STATUS, 8'h03);
      capture_pin <= 1'b1;
      repeat (8) @(posedge clk);
      chk("cap_rise", i == 0 || i == 2, compare_a_flag);
      w(`STM_ADDR_STATUS, 8'h03);
      capture_pin <= 1'b0;
      repeat (8) @(posedge clk);
      chk("cap_fall", i == 1 || i == 2, compare_a_flag);
    end
    chk("mode", STM_MODE_CAPTURE, mode_out);
    $display("test capture done");
  endtask : t_capture

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // Tests take about 7000 cycles; the watchdog allows 50000
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_clock();
    t_period();
    t_pause();
    t_output();
    t_match();
    t_pwm();
    t_capture();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
